/* dv/buf_side_model.sv */
// Status bits plus memory timer stand-in for the scheduler.
// Assumes loads and serving never collide in one clock.
module buf_side_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        load,
    input  wire logic [31:0] load_pat,
    input  wire logic        serve_en,
    input  wire logic        wr_req_q,
    input  wire logic        rd_req_q,
    input  wire logic [1:0]  req_ptr_q,
    output logic      [15:0] valid,
    output logic      [7:0]  pend
);
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------------------------------------
// Status update
// ----------------------------------------------------------------------
always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        valid <= '0;
        pend <= '0;
    end else if (load) begin
        for (int i = 0; i < 4; i++) begin
            valid[4*i+:4] <= load_pat[8*i+2+:4];
            pend[2*i+:2] <= load_pat[8*i+:2];
        end
    end else if (serve_en && rd_req_q) begin
        valid[4*req_ptr_q+:4] <= 4'hf;
    end else if (serve_en && wr_req_q) begin
        pend[2*req_ptr_q+:2] <= 2'h0;
    end
end
endmodule

/* dv/op_scheduler_assertions.sv */
// Checker for the write buffer operation scheduler.
// Assumes bind to op_scheduler; sees its ports only.
module op_scheduler_checker #(
    parameter LOCS = 4,
    parameter PTRW = 2
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [4*LOCS-1:0] buffer_status_valid,
    input wire logic [2*LOCS-1:0] buffer_status_pend,
    input wire logic [PTRW-1:0]   buffer_pointer_latch,
    input wire logic              last_written_gate_n,
    input wire logic              drain_all_diag,
    input wire logic              wr_req_q,
    input wire logic              rd_req_q,
    input wire logic [PTRW-1:0]   req_ptr_q,
    input wire logic              wr64_q,
    input wire logic              wr32_odd_q,
    input wire logic [PTRW-1:0]   last_written_latch_q
);
// ----------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
logic [4*LOCS-1:0] v_q;
logic [2*LOCS-1:0] p_q;
logic              quiet_q;
wire  [7:0] pd = buffer_status_pend;
wire  [5:0] pat = {v_q[4*req_ptr_q+:4], p_q[2*req_ptr_q+:2]};
wire  [2:0] cnt = 3'(|pd[7:6]) + 3'(|pd[5:4]) + 3'(|pd[3:2]) + 3'(|pd[1:0]);
wire        calm = quiet_q & !drain_all_diag & (pd[1:0] == 2'h0);
always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        v_q <= '0;
        p_q <= '0;
        quiet_q <= 1'b1;
    end else begin
        v_q <= buffer_status_valid;
        p_q <= buffer_status_pend;
        quiet_q <= (pd == 8'h00) | calm;
    end
end
a_no_both: assert property (!(wr_req_q && rd_req_q))
    else $error("both requests high");
a_empty_idle: assert property (pd == 8'h00 |=> !wr_req_q && !rd_req_q)
    else $error("request with nothing pending");
a_latch_copy: assert property (!last_written_gate_n |=>
    last_written_latch_q == $past(buffer_pointer_latch))
    else $error("latch not loaded");
a_latch_hold: assert property (last_written_gate_n |=>
    $stable(last_written_latch_q)) else $error("latch moved");
a_single_idle: assert property (calm && cnt == 3'h1 |=>
    !wr_req_q && !rd_req_q) else $error("request with one pending");
a_pair_nofill: assert property (calm && cnt == 3'h2 |=> !rd_req_q)
    else $error("fill with two pending");
a_skip_latch: assert property (calm && last_written_gate_n |=>
    !(wr_req_q || rd_req_q) || req_ptr_q != $past(last_written_latch_q))
    else $error("last written chosen");
a_wr64_pat: assert property (wr64_q |-> wr_req_q && pat == 6'h3f)
    else $error("bad 64-bit write");
a_wr32_pat: assert property (wr_req_q && !wr64_q |-> (wr32_odd_q ?
    pat inside {6'h3d, 6'h0d} : pat inside {6'h3e, 6'h32}))
    else $error("bad 32-bit write");
a_rd_unal: assert property (rd_req_q |-> pat[1:0] != 2'h0 && !(pat inside
    {6'h3f, 6'h3e, 6'h32, 6'h3d, 6'h0d})) else $error("bad fill read");
c_wr64: cover property (wr_req_q && wr64_q);
c_odd: cover property (wr_req_q && wr32_odd_q);
c_fill: cover property (rd_req_q);
endmodule

bind op_scheduler op_scheduler_checker #(.LOCS(LOCS), .PTRW(PTRW)) u_chk (
    .clk(clk), .arst_n(arst_n), .buffer_status_valid(buffer_status_valid),
    .buffer_status_pend(buffer_status_pend),
    .buffer_pointer_latch(buffer_pointer_latch),
    .last_written_gate_n(last_written_gate_n),
    .drain_all_diag(drain_all_diag), .wr_req_q(wr_req_q),
    .rd_req_q(rd_req_q), .req_ptr_q(req_ptr_q), .wr64_q(wr64_q),
    .wr32_odd_q(wr32_odd_q), .last_written_latch_q(last_written_latch_q));

/* dv/op_scheduler_tb.sv */
// Self-checking bench for the operation scheduler.
// Assumes buf_side_model and the bound checker are compiled alongside.
module op_scheduler_tb;
timeunit 1ns;
timeprecision 1ps;
logic clk = 0, arst_n = 0, gate_n = 1, drain = 0, load = 0, serve = 0;
logic [1:0] ptr = 2'h0;
logic [31:0] pat = '0;
wire [15:0] valid;
wire [7:0] pend;
wire wr, rd, w64, odd;
wire [1:0] rp, lwq;
int err_total = 0, num_checks = 0;
logic [1:0] lw [10] = '{0, 2, 3, 1, 3, 1, 3, 3, 0, 2};
logic [31:0] pt [10] = '{32'h0, 32'h003f0000, 32'h3f003200, 32'h22003f00,
    32'h3f3d3f00, 32'h22223f00, 32'h3f0d3200, 32'h3f223e3f, 32'h22112122,
    32'h003f003e};
logic [5:0] ex [10] = '{6'h00, 6'h00, 6'h24, 6'h00, 6'h26, 6'h1c, 6'h29,
    6'h22, 6'h1c, 6'h20};
op_scheduler #(.LOCS(4), .PTRW(2)) dut (.clk(clk), .arst_n(arst_n),
    .buffer_status_valid(valid), .buffer_status_pend(pend),
    .buffer_pointer_latch(ptr), .last_written_gate_n(gate_n),
    .drain_all_diag(drain), .wr_req_q(wr), .rd_req_q(rd), .req_ptr_q(rp),
    .wr64_q(w64), .wr32_odd_q(odd), .last_written_latch_q(lwq));
buf_side_model mdl (.clk(clk), .arst_n(arst_n), .load(load),
    .load_pat(pat), .serve_en(serve), .wr_req_q(wr), .rd_req_q(rd),
    .req_ptr_q(rp), .valid(valid), .pend(pend));
// ----------------------------------------------------------------------
// Tasks and sequence
// ----------------------------------------------------------------------
task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
        err_total++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task set_lw(input logic [1:0] p);
    @(posedge clk) {ptr, gate_n} <= {p, 1'b0};
    @(posedge clk) gate_n <= 1'b1;
endtask
task ld(input logic [31:0] p);
    @(posedge clk) {pat, load} <= {p, 1'b1};
    @(posedge clk) load <= 1'b0;
endtask
task drain_out;
    int n;
    for (n = 0; n < 60 && pend !== 8'h00; n++) @(posedge clk);
    chk(pend, 8'h00);
endtask
initial forever #25 clk = ~clk;
initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
end
initial begin
    logic [5:0] m;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk({wr, rd, rp, w64, odd, lwq}, 8'h00);
    set_lw(2'h3);
    #1 chk(lwq, 8'h03);
    for (int i = 0; i < 10; i++) begin
        set_lw(lw[i]);
        ld(pt[i]);
        repeat (2) @(posedge clk);
        m = ex[i][5] ? 6'h3f : (ex[i][4] ? 6'h3c : 6'h30);
        #1 chk({wr, rd, rp, w64, odd} & m, ex[i]);
        ld(32'h0);
        repeat (3) @(posedge clk);
    end
    set_lw(2'h2);
    ld(32'h00222100);
    @(posedge clk) {drain, serve} <= 2'b11;
    drain_out;
    chk(valid[11:8], 8'h0f);
    @(posedge clk) {drain, serve} <= 2'b00;
    set_lw(2'h0);
    ld(32'h00000022);
    set_lw(2'h1);
    ld(32'h3f003f22);
    @(posedge clk) serve <= 1'b1;
    drain_out;
    print_verdict;
end
endmodule

/* pkg/op_scheduler_map.vh */
// Constants for the write buffer operation scheduler.
// Assumes inclusion by the scheduler and its location classifier only.
`ifndef OP_SCHEDULER_MAP_VH
`define OP_SCHEDULER_MAP_VH

// ----------------------------------------------------------------------
// Status pattern layout {valid[3:0], pend[1:0]}
// ----------------------------------------------------------------------
`define PAT_VALID_MSB    5
`define PAT_VALID_LSB    2
`define PAT_PEND_EVEN    1
`define PAT_PEND_ODD     0

// ----------------------------------------------------------------------
// Aligned patterns
// ----------------------------------------------------------------------
`define PAT_AL64         6'h3f
`define PAT_AL32_EVEN_A  6'h3e
`define PAT_AL32_EVEN_B  6'h32
`define PAT_AL32_ODD_A   6'h3d
`define PAT_AL32_ODD_B   6'h0d

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LAST_WRITTEN 2'h0
`define RST_REQ_PTR      2'h0

`endif

/* src/loc_classifier.v */
// Classifier for one write buffer location from its status bits.
// Assumes valid and pending bits stable for the clock it is sampled in.
`include "op_scheduler_map.vh"

module loc_classifier (
    input  wire [3:0] valid,
    input  wire [1:0] pend,
    output wire       pend_any,
    output wire       al64,
    output wire       al32,
    output wire       al32_odd,
    output wire       unaligned
);
    wire [5:0] pat;
    wire       even_hit;
    wire       odd_hit;

    // ------------------------------------------------------------------
    // Pattern match
    // ------------------------------------------------------------------
    assign pat       = {valid, pend};
    assign pend_any  = |pend;
    assign al64      = (pat == `PAT_AL64);
    assign even_hit  = (pat == `PAT_AL32_EVEN_A) |
                       (pat == `PAT_AL32_EVEN_B);
    assign odd_hit   = (pat == `PAT_AL32_ODD_A) |
                       (pat == `PAT_AL32_ODD_B);
    assign al32      = even_hit | odd_hit;
    assign al32_odd  = odd_hit;
    // Any other pending pattern needs a fill read first
    assign unaligned = pend_any & ~al64 & ~al32;
endmodule

/* src/op_scheduler.v */
// Write buffer operation scheduler: picks the next memory operation.
// Assumes buffer status bits and pointer latch are synchronous to clk;
// the memory timer samples the registered requests each clock.
`include "op_scheduler_map.vh"

module op_scheduler #(
    parameter LOCS = 4,
    parameter PTRW = 2
) (
    input  wire              clk,
    input  wire              arst_n,
    input  wire [4*LOCS-1:0] buffer_status_valid,
    input  wire [2*LOCS-1:0] buffer_status_pend,
    input  wire [PTRW-1:0]   buffer_pointer_latch,
    input  wire              last_written_gate_n,
    input  wire              drain_all_diag,
    output reg               wr_req_q,
    output reg               rd_req_q,
    output reg  [PTRW-1:0]   req_ptr_q,
    output reg               wr64_q,
    output reg               wr32_odd_q,
    output reg  [PTRW-1:0]   last_written_latch_q
);
    // ------------------------------------------------------------------
    // Per-location classification
    // ------------------------------------------------------------------
    wire [LOCS-1:0] pend_any;
    wire [LOCS-1:0] al64;
    wire [LOCS-1:0] al32;
    wire [LOCS-1:0] al32_odd;
    wire [LOCS-1:0] unal;

    genvar g;
    generate
        for (g = 0; g < LOCS; g = g + 1) begin : g_loc
            loc_classifier u_cls (
                .valid     (buffer_status_valid[4*g +: 4]),
                .pend      (buffer_status_pend[2*g +: 2]),
                .pend_any  (pend_any[g]),
                .al64      (al64[g]),
                .al32      (al32[g]),
                .al32_odd  (al32_odd[g]),
                .unaligned (unal[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Last-written latch
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_written_latch_q <= `RST_LAST_WRITTEN;
        end else if (!last_written_gate_n) begin
            last_written_latch_q <= buffer_pointer_latch;
        end
    end

    // ------------------------------------------------------------------
    // Location 0 starvation flush
    // ------------------------------------------------------------------
    reg  flush_q;
    reg  flush_d;
    wire empty;

    assign empty = ~|pend_any;

    always @* begin
        flush_d = flush_q;
        if (empty) begin
            flush_d = 1'b0;
        end else if (unal[0] &&
                     (last_written_latch_q != {PTRW{1'b0}})) begin
            flush_d = 1'b1;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
        end
    end

    // ------------------------------------------------------------------
    // Pending count and candidate set
    // ------------------------------------------------------------------
    reg [PTRW:0]   cnt;
    reg [LOCS-1:0] cand;
    reg            bypass;
    integer        i;

    always @* begin
        cnt    = {(PTRW+1){1'b0}};
        cand   = {LOCS{1'b0}};
        bypass = drain_all_diag | flush_q;
        for (i = 0; i < LOCS; i = i + 1) begin
            cnt = cnt + {{PTRW{1'b0}}, pend_any[i]};
            if (pend_any[i] && (bypass ||
                (i[PTRW-1:0] != last_written_latch_q))) begin
                cand[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Selection by kind, highest pointer wins
    // ------------------------------------------------------------------
    reg            have64;
    reg            have32;
    reg            haveun;
    reg [PTRW-1:0] ptr64;
    reg [PTRW-1:0] ptr32;
    reg [PTRW-1:0] ptrun;
    reg            odd32;
    integer        j;

    always @* begin
        have64 = 1'b0;
        have32 = 1'b0;
        haveun = 1'b0;
        ptr64  = {PTRW{1'b0}};
        ptr32  = {PTRW{1'b0}};
        ptrun  = {PTRW{1'b0}};
        odd32  = 1'b0;
        // Ascending scan so later hits overwrite: highest pointer kept
        for (j = 0; j < LOCS; j = j + 1) begin
            if (cand[j] && al64[j]) begin
                have64 = 1'b1;
                ptr64  = j[PTRW-1:0];
            end
            if (cand[j] && al32[j]) begin
                have32 = 1'b1;
                ptr32  = j[PTRW-1:0];
                odd32  = al32_odd[j];
            end
            if (cand[j] && unal[j]) begin
                haveun = 1'b1;
                ptrun  = j[PTRW-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------------
    reg            wr_d;
    reg            rd_d;
    reg [PTRW-1:0] ptr_d;
    reg            wr64_d;
    reg            odd_d;
    reg            allow_wr;
    reg            allow_rd;

    always @* begin
        allow_wr = 1'b0;
        allow_rd = 1'b0;
        if (bypass) begin
            allow_wr = 1'b1;
            allow_rd = 1'b1;
        end else if (cnt == 3'd2) begin
            allow_wr = 1'b1;
        end else if (cnt >= 3'd3) begin
            allow_wr = 1'b1;
            allow_rd = 1'b1;
        end
        // Count 0 leaves both off; count 1 does too unless bypass is set
        if (empty) begin
            allow_wr = 1'b0;
            allow_rd = 1'b0;
        end else if (!bypass && cnt == 3'd1) begin
            allow_wr = 1'b0;
            allow_rd = 1'b0;
        end

        wr_d   = 1'b0;
        rd_d   = 1'b0;
        ptr_d  = req_ptr_q;
        wr64_d = 1'b0;
        odd_d  = 1'b0;
        if (allow_wr && have64) begin
            wr_d   = 1'b1;
            wr64_d = 1'b1;
            ptr_d  = ptr64;
        end else if (allow_wr && have32) begin
            wr_d   = 1'b1;
            odd_d  = odd32;
            ptr_d  = ptr32;
        end else if (allow_rd && haveun) begin
            rd_d   = 1'b1;
            ptr_d  = ptrun;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs to the memory timer and pointer mux
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_req_q   <= 1'b0;
            rd_req_q   <= 1'b0;
            req_ptr_q  <= `RST_REQ_PTR;
            wr64_q     <= 1'b0;
            wr32_odd_q <= 1'b0;
        end else begin
            wr_req_q   <= wr_d;
            rd_req_q   <= rd_d;
            req_ptr_q  <= ptr_d;
            wr64_q     <= wr64_d;
            wr32_odd_q <= odd_d;
        end
    end
endmodule
